// ### verilog/ecm_crosscheck.sv
/*
 Dual-channel encoder supervision: quadrature decoding, position and speed
 per channel, averaging filter, line fault detection and cross-comparison
 with a latched shut-down request.
 Assumes each channel has two tracks with complementary lines on pins.
*/
`timescale 1ns/1ps
`default_nettype none

// What this block does
// RL1 - Continuously compare position and speed across channels
// RL2 - Position difference checked against position threshold
// RL3 - Speed difference checked against speed threshold
// RL4 - Edge counting at 500 Hz, period timing below
// RL5 - Acceleration window peak time capped at 256 ms
// RL6 - Optional moving-average filter on speed values
// RL7 - Filter length 0 to 64 ms, 8 ms steps
// RL8 - Detect shorts and open lines on encoder wiring
// RL9 - Detect lines stuck at 0 or 1
// RL10 - Latch fault, request safe stop until reset
module ecm_crosscheck import ecm_pkg::*; #(
   parameter int unsigned MS_CYC = MS_CYC_DEF,
   parameter int unsigned PEAK_CYC = PEAK_CYC_DEF
) (
   // Clock, reset, enable
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic ce,
   // Encoder pins: [1:0] channel A tracks, [3:2] channel B tracks
   input wire logic [3:0] enc_trk,
   input wire logic [3:0] enc_trk_n,
   // Configuration
   input wire logic [POS_W-1:0] pos_thresh,
   input wire logic [SPD_W-1:0] spd_thresh,
   input wire logic [FILT_SEL_W-1:0] filt_sel,
   // Measured values
   output logic signed [POS_W-1:0] pos_a,
   output logic signed [POS_W-1:0] pos_b,
   output logic signed [SPD_W-1:0] spd_a,
   output logic signed [SPD_W-1:0] spd_b,
   output logic signed [SPD_W-1:0] acc_a,
   output logic signed [SPD_W-1:0] acc_b,
   output logic [1:0] period_mode,
   // Faults
   output logic fault_pos,
   output logic fault_spd,
   output logic [1:0] fault_line,
   output logic safe_stop_req
);

   // ----------------------------------------------------------------
   // Time bases
   // ----------------------------------------------------------------
   localparam int unsigned MS_W = $clog2(MS_CYC + 1);
   localparam logic [MS_W-1:0] MS_LAST = MS_W'(MS_CYC - 1);
   localparam logic [3:0] GATE_LAST = 4'(GATE_MS - 1);
   localparam logic [CNT_W-1:0] PEAK_LIM = CNT_W'(PEAK_CYC);

   logic [MS_W-1:0] ms_cnt_r;
   logic [3:0] gate_cnt_r;
   logic ms_tick;
   logic gate_tick;
   logic [FILT_SEL_W-1:0] filt_k;

   assign ms_tick = (ms_cnt_r == MS_LAST);
   assign gate_tick = ms_tick && (gate_cnt_r == GATE_LAST);
   assign filt_k = (filt_sel > FILT_SEL_MAX) ? FILT_SEL_MAX : filt_sel; // [RL7]

   // Millisecond and gate interval counters
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ms_cnt_r <= '0;
         gate_cnt_r <= '0;
      end else if (ce) begin
         ms_cnt_r <= ms_tick ? '0 : ms_cnt_r + 1'b1;
         if (ms_tick) begin
            gate_cnt_r <= (gate_cnt_r == GATE_LAST) ? 4'h0 : gate_cnt_r + 4'h1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Per-channel measurement
   // ----------------------------------------------------------------
   logic signed [POS_W-1:0] pos_r [2];
   logic signed [SPD_W-1:0] spd_f_r [2];
   logic signed [SPD_W-1:0] acc_r [2];
   logic [1:0] slow_r;
   logic [1:0] line_bad;

   for (genvar ch = 0; ch < 2; ch++) begin : g_ch
      logic [3:0] s1_r, s2_r;
      logic [2:0] live_r;
      logic [1:0] q, qn, q_prev_r, chg;
      logic step, up, illegal;
      logic [EDGE_W-1:0] edge_cnt_r;
      logic [CNT_W-1:0] per_cnt_r, per_lat_r, dvs, dvs_r;
      logic dir_r;
      logic div_busy_r;
      logic [4:0] div_i_r;
      logic [DIV_W:0] rem_r, trial;
      logic [DIV_W-1:0] quo_r;
      logic signed [SPD_W-1:0] spd_raw_r, spd_prev_r;
      logic spd_upd_r;
      logic [FILT_SEL_W-1:0] fms_r;
      logic [FILT_AW-1:0] wptr_r;
      logic [FILT_AW:0] fill_r;
      logic samp;
      logic [SPD_W-1:0] old_raw;
      logic signed [SPD_W-1:0] old_val;
      logic signed [SPD_W+FILT_AW-1:0] sum_r;
      logic [LFC_W-1:0] lfc_r;
      logic pair_eq;

      // Pin synchroniser, two flops; live_r marks when the pipe holds real pins,
      // so an encoder resting off 00 at reset is not taken for a jump
      always_ff @(posedge ref_clk or posedge rst) begin
         if (rst) begin
            s1_r <= 4'h0;
            s2_r <= 4'h0;
            live_r <= 3'h0;
         end else if (ce) begin
            s1_r <= {enc_trk_n[2*ch +: 2], enc_trk[2*ch +: 2]};
            s2_r <= s1_r;
            live_r <= {live_r[1:0], 1'b1};
         end
      end

      assign q = s2_r[1:0];
      assign qn = s2_r[3:2];
      assign chg = live_r[2] ? (q ^ q_prev_r) : 2'h0; // No edge before the pipe is live
      assign step = ^chg;
      assign illegal = &chg; // Both tracks jump at once: shorted lines [RL8]
      assign up = q_prev_r[1] ^ q[0];

      // Quadrature position counter
      always_ff @(posedge ref_clk or posedge rst) begin
         if (rst) begin
            q_prev_r <= 2'h0;
            pos_r[ch] <= '0;
            dir_r <= 1'b0;
         end else if (ce) begin
            q_prev_r <= q;
            if (step) begin
               pos_r[ch] <= up ? pos_r[ch] + 1'b1 : pos_r[ch] - 1'b1;
               dir_r <= ~up;
            end
         end
      end

      // Edge count per gate and period timer capped at peak time
      always_ff @(posedge ref_clk or posedge rst) begin
         if (rst) begin
            edge_cnt_r <= '0;
            per_cnt_r <= '0;
            per_lat_r <= PEAK_LIM;
         end else if (ce) begin
            if (gate_tick) begin
               edge_cnt_r <= {{(EDGE_W-1){1'b0}}, step};
            end else if (step && edge_cnt_r != '1) begin
               edge_cnt_r <= edge_cnt_r + 1'b1;
            end
            if (step) begin
               per_lat_r <= per_cnt_r + 1'b1;
               per_cnt_r <= '0;
            end else if (per_cnt_r < PEAK_LIM) begin
               per_cnt_r <= per_cnt_r + 1'b1; // Saturates at peak time [RL5]
            end
         end
      end

      // A slowing shaft is judged by the longer of the open and last period
      assign dvs = (per_cnt_r > per_lat_r) ? per_cnt_r : per_lat_r;
      assign trial = {rem_r[DIV_W-1:0], DIVIDEND[5'(DIV_W-1) - div_i_r]};

      // Speed: edge counting fast, period division slow
      always_ff @(posedge ref_clk or posedge rst) begin
         if (rst) begin
            div_busy_r <= 1'b0;
            div_i_r <= 5'h00;
            rem_r <= '0;
            quo_r <= '0;
            spd_raw_r <= '0;
            spd_prev_r <= '0;
            dvs_r <= '0;
            spd_upd_r <= 1'b0;
            slow_r[ch] <= 1'b1;
         end else if (ce) begin
            spd_upd_r <= 1'b0;
            if (gate_tick && !div_busy_r) begin
               if (edge_cnt_r >= EDGE_W'(FREQ_MIN_EDGES)) begin // [RL4]
                  spd_raw_r <= dir_r ? -SPD_W'(edge_cnt_r * FREQ_MUL)
                                     : SPD_W'(edge_cnt_r * FREQ_MUL);
                  slow_r[ch] <= 1'b0;
                  spd_upd_r <= 1'b1;
               end else if (dvs >= PEAK_LIM) begin
                  spd_raw_r <= '0; // No edge within peak time: standstill [RL5]
                  slow_r[ch] <= 1'b1;
                  spd_upd_r <= 1'b1;
               end else begin
                  div_busy_r <= 1'b1; // Period method [RL4]
                  div_i_r <= 5'h00;
                  rem_r <= '0;
                  quo_r <= '0;
                  dvs_r <= dvs; // Open period keeps growing, so freeze the divisor
                  slow_r[ch] <= 1'b1;
               end
            end else if (div_busy_r) begin
               if (trial >= {{(DIV_W+1-CNT_W){1'b0}}, dvs_r}) begin
                  rem_r <= trial - {{(DIV_W+1-CNT_W){1'b0}}, dvs_r};
                  quo_r <= {quo_r[DIV_W-2:0], 1'b1};
               end else begin
                  rem_r <= trial;
                  quo_r <= {quo_r[DIV_W-2:0], 1'b0};
               end
               div_i_r <= div_i_r + 5'h01;
               if (div_i_r == 5'(DIV_W-1)) begin
                  div_busy_r <= 1'b0;
                  spd_upd_r <= 1'b1;
               end
            end
            if (div_busy_r && div_i_r == 5'(DIV_W-1)) begin
               spd_raw_r <= dir_r ? -SPD_W'({quo_r[DIV_W-2:0], trial >= dvs_r})
                                  : SPD_W'({quo_r[DIV_W-2:0], trial >= dvs_r});
            end
            if (spd_upd_r) begin
               spd_prev_r <= spd_raw_r;
            end
         end
      end

      // Acceleration as speed change per measuring window
      always_ff @(posedge ref_clk or posedge rst) begin
         if (rst) begin
            acc_r[ch] <= '0;
         end else if (ce && spd_upd_r) begin
            acc_r[ch] <= spd_raw_r - spd_prev_r; // [RL5]
         end
      end

      // Averaging filter: eight samples spaced filt_k ms apart
      assign samp = ms_tick && (filt_k != '0) && (fms_r + 1'b1 >= filt_k);
      assign old_val = (fill_r >= (FILT_AW+1)'(FILT_DEPTH)) ? $signed(old_raw) : '0;

      ecm_ring_mem #(
         .W(SPD_W),
         .AW(FILT_AW)
      ) u_ring (
         .ref_clk(ref_clk),
         .ce(ce),
         .we(samp),
         .waddr(wptr_r),
         .wdata(spd_raw_r),
         .raddr(wptr_r),
         .rdata_r(old_raw)
      );

      always_ff @(posedge ref_clk or posedge rst) begin
         if (rst) begin
            fms_r <= '0;
            wptr_r <= '0;
            fill_r <= '0;
            sum_r <= '0;
            spd_f_r[ch] <= '0;
         end else if (ce) begin
            if (filt_k == '0) begin
               fms_r <= '0;
               fill_r <= '0;
               sum_r <= '0;
               spd_f_r[ch] <= spd_raw_r; // Filter bypassed [RL6]
            end else begin
               if (ms_tick) begin
                  fms_r <= samp ? '0 : fms_r + 1'b1;
               end
               if (samp) begin
                  sum_r <= sum_r + (SPD_W+FILT_AW)'(spd_raw_r)
                                 - (SPD_W+FILT_AW)'(old_val); // [RL6]
                  wptr_r <= wptr_r + 1'b1;
                  if (fill_r < (FILT_AW+1)'(FILT_DEPTH)) begin
                     fill_r <= fill_r + 1'b1;
                  end
               end
               // Until the window fills, the raw value passes through
               spd_f_r[ch] <= (fill_r >= (FILT_AW+1)'(FILT_DEPTH))
                              ? SPD_W'(sum_r >>> FILT_AW) : spd_raw_r; // [RL7]
            end
         end
      end

      // Line supervision: a track equal to its complement is open or stuck
      assign pair_eq = live_r[2] && ((q[0] == qn[0]) || (q[1] == qn[1]));

      always_ff @(posedge ref_clk or posedge rst) begin
         if (rst) begin
            lfc_r <= '0;
         end else if (ce) begin
            lfc_r <= !pair_eq ? '0 : (lfc_r == LFC_W'(LINE_FLT_CYC)) ? lfc_r
                                   : lfc_r + 1'b1; // [RL8] [RL9]
         end
      end

      assign line_bad[ch] = illegal || (lfc_r == LFC_W'(LINE_FLT_CYC)); // [RL8] [RL9]
   end

   // ----------------------------------------------------------------
   // Cross-channel comparison and fault latch
   // ----------------------------------------------------------------
   logic signed [POS_W:0] pos_diff;
   logic signed [SPD_W:0] spd_diff;
   logic [POS_W:0] pos_abs;
   logic [SPD_W:0] spd_abs;
   logic pos_over, spd_over;

   assign pos_diff = {pos_r[0][POS_W-1], pos_r[0]} - {pos_r[1][POS_W-1], pos_r[1]};
   assign spd_diff = {spd_f_r[0][SPD_W-1], spd_f_r[0]} - {spd_f_r[1][SPD_W-1], spd_f_r[1]};
   assign pos_abs = pos_diff[POS_W] ? -pos_diff : pos_diff;
   assign spd_abs = spd_diff[SPD_W] ? -spd_diff : spd_diff;
   assign pos_over = pos_abs > {1'b0, pos_thresh}; // [RL1] [RL2]
   assign spd_over = spd_abs > {1'b0, spd_thresh}; // [RL1] [RL3]

   // Faults stay latched until reset
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         fault_pos <= 1'b0;
         fault_spd <= 1'b0;
         fault_line <= 2'h0;
      end else if (ce) begin
         fault_pos <= fault_pos | pos_over; // [RL10]
         fault_spd <= fault_spd | spd_over; // [RL10]
         fault_line <= fault_line | line_bad; // [RL10]
      end
   end

   assign safe_stop_req = fault_pos | fault_spd | (|fault_line); // [RL10]

   // Measured value outputs
   assign pos_a = pos_r[0];
   assign pos_b = pos_r[1];
   assign spd_a = spd_f_r[0];
   assign spd_b = spd_f_r[1];
   assign acc_a = acc_r[0];
   assign acc_b = acc_r[1];
   assign period_mode = slow_r;

endmodule // ecm_crosscheck

`default_nettype wire

// ### verilog/ecm_pkg.sv
/*
 Shared constants of the encoder cross-check monitor: clock rate, measuring
 intervals, filter geometry and data widths.
 Assumes a single 25 MHz system clock.
*/
`default_nettype none

package ecm_pkg;

   // ----------------------------------------------------------------
   // Clock and derived time bases
   // ----------------------------------------------------------------
   localparam int unsigned CLK_HZ = 25_000_000;
   localparam int unsigned MS_CYC_DEF = CLK_HZ / 1000;
   localparam int unsigned GATE_MS = 8;
   localparam int unsigned FREQ_MIN_HZ = 500;
   localparam int unsigned FREQ_MIN_EDGES = FREQ_MIN_HZ * GATE_MS / 1000;
   localparam int unsigned FREQ_MUL = 1000 / GATE_MS;
   localparam int unsigned PEAK_MS = 256;
   localparam int unsigned PEAK_CYC_DEF = (CLK_HZ / 1000) * PEAK_MS;
   localparam int unsigned LINE_FLT_US = 100;
   localparam int unsigned LINE_FLT_CYC = (CLK_HZ / 1_000_000) * LINE_FLT_US;

   // ----------------------------------------------------------------
   // Averaging filter
   // ----------------------------------------------------------------
   localparam int unsigned FILT_STEP_MS = 8;
   localparam int unsigned FILT_MAX_MS = 64;
   localparam int unsigned FILT_DEPTH = 8;
   localparam int unsigned FILT_AW = 3;
   localparam int unsigned FILT_SEL_W = 4;
   localparam logic [FILT_SEL_W-1:0] FILT_SEL_MAX = 4'h8;

   // ----------------------------------------------------------------
   // Data widths
   // ----------------------------------------------------------------
   localparam int unsigned POS_W = 32;
   localparam int unsigned SPD_W = 32;
   localparam int unsigned CNT_W = 24;
   localparam int unsigned DIV_W = 25;
   localparam int unsigned EDGE_W = 16;
   localparam int unsigned LFC_W = 12;
   localparam logic [DIV_W-1:0] DIVIDEND = DIV_W'(CLK_HZ);

endpackage : ecm_pkg

`default_nettype wire

// ### verilog/ecm_ring_mem.sv
/*
 Small ring memory for the averaging filter: one write port and one read
 port whose data come out of a register.
 Assumes write and read addresses come from the same clock domain.
*/
`timescale 1ns/1ps
`default_nettype none

module ecm_ring_mem #(
   parameter int unsigned W = 32,
   parameter int unsigned AW = 3
) (
   // Clock
   input wire logic ref_clk,
   input wire logic ce,
   // Write port
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [W-1:0] wdata,
   // Read port
   input wire logic [AW-1:0] raddr,
   output logic [W-1:0] rdata_r
);

   logic [W-1:0] mem [2**AW];

   // Storage write and registered read
   always_ff @(posedge ref_clk) begin
      if (ce) begin
         if (we) begin
            mem[waddr] <= wdata;
         end
         rdata_r <= mem[raddr];
      end
   end

endmodule // ecm_ring_mem

`default_nettype wire

// ### tb/ecm_enc_model.sv
/*
 Two-channel quadrature encoder model with wiring faults on demand.
 Assumes the bench pulses step, skip and stuck just after a rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
module ecm_enc_model (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Motion per channel
   input wire logic [1:0] step,
   input wire logic [1:0] fwd,
   input wire logic [1:0] skip,
   // Wiring faults per channel
   input wire logic [1:0] stuck,
   input wire logic stuck_lvl,
   // Encoder pins
   output logic [3:0] enc_trk,
   output logic [3:0] enc_trk_n
);
   logic [1:0] q_r [2];
   // Phase counters, one per channel
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         q_r[0] <= 2'h0;
         q_r[1] <= 2'h0;
      end else begin
         for (int c = 0; c < 2; c++) begin
            if (skip[c]) q_r[c] <= q_r[c] + 2'h2; // Both tracks flip
            else if (step[c]) q_r[c] <= fwd[c] ? q_r[c] + 2'h1 : q_r[c] - 2'h1;
         end
      end
   end
   // Gray tracks with complements, or all four lines of a channel forced on its fault
   always_comb begin
      for (int c = 0; c < 2; c++) begin
         enc_trk[2*c +: 2] = stuck[c] ? {2{stuck_lvl}} : {q_r[c][1], ^q_r[c]};
         enc_trk_n[2*c +: 2] = stuck[c] ? {2{stuck_lvl}} : ~{q_r[c][1], ^q_r[c]};
      end
   end
endmodule // ecm_enc_model
`default_nettype wire

// ### tb/ecm_crosscheck_checker.sv
/*
 Port checker for the cross-check monitor.
 Assumes one clock and ce held high.
*/
`timescale 1ns/1ps
`default_nettype none
module ecm_crosscheck_checker import ecm_pkg::*; (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic ce,
   // Pins and limits
   input wire logic [3:0] enc_trk,
   input wire logic [3:0] enc_trk_n,
   input wire logic [POS_W-1:0] pos_thresh,
   input wire logic [SPD_W-1:0] spd_thresh,
   // Results
   input wire logic signed [POS_W-1:0] pos_a,
   input wire logic signed [POS_W-1:0] pos_b,
   input wire logic signed [SPD_W-1:0] spd_a,
   input wire logic signed [SPD_W-1:0] spd_b,
   input wire logic fault_pos,
   input wire logic fault_spd,
   input wire logic [1:0] fault_line,
   input wire logic safe_stop_req
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   logic signed [32:0] pd;
   logic signed [32:0] sd;
   logic [32:0] pdev;
   logic [32:0] sdev;
   logic pos_over;
   logic spd_over;
   logic [12:0] eq_cnt_r;
   // Magnitudes of the cross-channel differences
   assign pd = {pos_a[31], pos_a} - {pos_b[31], pos_b};
   assign sd = {spd_a[31], spd_a} - {spd_b[31], spd_b};
   assign pdev = pd[32] ? -pd : pd;
   assign sdev = sd[32] ? -sd : sd;
   assign pos_over = pdev > {1'b0, pos_thresh};
   assign spd_over = sdev > {1'b0, spd_thresh};
   // Cycles that channel B track 0 equals its complement
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) eq_cnt_r <= 13'h0;
      else if (enc_trk[2] != enc_trk_n[2]) eq_cnt_r <= 13'h0;
      else if (eq_cnt_r != 13'h1fff) eq_cnt_r <= eq_cnt_r + 13'h1;
   end
   a_stop_from_faults: assert property (
      safe_stop_req == (fault_pos | fault_spd | (|fault_line))) else $error("stop request");
   a_pos_fault_held: assert property (fault_pos |=> fault_pos)
      else $error("position fault dropped");
   a_spd_fault_held: assert property (fault_spd |=> fault_spd)
      else $error("speed fault dropped");
   a_line_fault_held: assert property ((fault_line != 2'h0) |=>
      ((fault_line & $past(fault_line)) == $past(fault_line))) else $error("line fault dropped");
   a_pos_trip: assert property (ce && pos_over |=> fault_pos)
      else $error("position deviation missed");
   a_pos_cause: assert property ($rose(fault_pos) |-> $past(pos_over))
      else $error("position fault without deviation");
   a_spd_trip: assert property (ce && spd_over |=> fault_spd)
      else $error("speed deviation missed");
   a_spd_cause: assert property ($rose(fault_spd) |-> $past(spd_over))
      else $error("speed fault without deviation");
   a_pos_single_step: assert property ($changed(pos_a) |->
      (pos_a - $past(pos_a) == 1) || ($past(pos_a) - pos_a == 1)) else $error("position jump");
   a_line_stuck: assert property (eq_cnt_r > LINE_FLT_CYC + 10 |-> fault_line[1])
      else $error("stuck line missed");
endmodule // ecm_crosscheck_checker
bind ecm_crosscheck ecm_crosscheck_checker ecm_crosscheck_checker_i (
   .ref_clk(ref_clk), .rst(rst), .ce(ce), .enc_trk(enc_trk), .enc_trk_n(enc_trk_n),
   .pos_thresh(pos_thresh), .spd_thresh(spd_thresh), .pos_a(pos_a), .pos_b(pos_b),
   .spd_a(spd_a), .spd_b(spd_b), .fault_pos(fault_pos), .fault_spd(fault_spd),
   .fault_line(fault_line), .safe_stop_req(safe_stop_req));
`default_nettype wire

// ### tb/ecm_crosscheck_bench.sv
/*
 Self-checking bench for the cross-check monitor.
 Assumes MS_CYC 50 and PEAK_CYC 4000 to keep runs short.
*/
`timescale 1ns/1ps
`default_nettype none
module ecm_crosscheck_bench import ecm_pkg::*; ;
   typedef struct {int na; int nb; logic [1:0] dir; logic [31:0] th;
      logic [31:0] ea; logic [31:0] eb; logic ef;} ecm_row_t;
   ecm_row_t rows [5] = '{'{5, 5, 2'h3, 0, 5, 5, 0}, '{6, 3, 2'h3, 3, 6, 3, 0},
      '{6, 2, 2'h3, 3, 6, 2, 1}, '{3, 3, 2'h0, 0, -3, -3, 0}, '{4, 4, 2'h2, 7, -4, 4, 1}};
   logic ref_clk = 0;
   logic rst = 1;
   logic lvl = 0;
   logic [1:0] step = 0, fwd = 0, skip = 0, stuck = 0;
   logic [31:0] pth = 0, sth = '1;
   logic [3:0] fsel = 0;
   logic [3:0] trk, trk_n;
   logic signed [31:0] pa, pb, sa, sb, aa, ab;
   logic [1:0] pm, fl;
   logic fp, fs, ssr;
   int n_errors = 0, n_compared = 0, cyc = 0;
   ecm_enc_model ecm_enc_model_i (.ref_clk(ref_clk), .rst(rst), .step(step), .fwd(fwd),
      .skip(skip), .stuck(stuck), .stuck_lvl(lvl), .enc_trk(trk), .enc_trk_n(trk_n));
   ecm_crosscheck #(.MS_CYC(50), .PEAK_CYC(4000)) ecm_crosscheck_i (.ref_clk(ref_clk),
      .rst(rst), .ce(1'b1), .enc_trk(trk), .enc_trk_n(trk_n), .pos_thresh(pth),
      .spd_thresh(sth), .filt_sel(fsel), .pos_a(pa), .pos_b(pb), .spd_a(sa), .spd_b(sb),
      .acc_a(aa), .acc_b(ab), .period_mode(pm), .fault_pos(fp), .fault_spd(fs),
      .fault_line(fl), .safe_stop_req(ssr));
   // Clock and hang guard
   initial forever #20 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 40000) begin
         n_errors++;
         end_of_test;
      end
   end
   task end_of_test;
      if (n_errors == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected %s exp %h got %h", nm, exp, got);
      end
   endtask
   task near(input string nm, input int exp, input logic signed [31:0] got);
      n_compared++;
      if ((^got === 1'bx) || got < exp - 250 || got > exp + 250) begin
         n_errors++;
         $display("unexpected %s exp %0d got %0d", nm, exp, got);
      end
   endtask
   task do_reset;
      @(posedge ref_clk);
      rst <= 1;
      stuck <= 2'h0;
      repeat (20) @(posedge ref_clk);
      rst <= 0;
   endtask
   task run(input int na, input int nb, input logic [1:0] dir, input int gap);
      for (int i = 0; i < (na > nb ? na : nb); i++) begin
         @(posedge ref_clk);
         step <= {1'(i < nb), 1'(i < na)};
         fwd <= dir;
         @(posedge ref_clk);
         step <= 2'h0;
         repeat (gap - 2) @(posedge ref_clk);
      end
      repeat (6) @(posedge ref_clk);
   endtask
   // Main sequence: table rows, then speed, wiring and reset cases
   initial begin
      foreach (rows[r]) begin
         pth <= rows[r].th;
         do_reset;
         run(rows[r].na, rows[r].nb, rows[r].dir, 4);
         chk("pos_a", rows[r].ea, pa);
         chk("pos_b", rows[r].eb, pb);
         chk("fault_pos", 32'(rows[r].ef), 32'(fp));
         chk("safe_stop_req", 32'(rows[r].ef), 32'(ssr));
      end
      pth <= '1;
      sth <= 1000;
      do_reset;
      run(300, 300, 2'h3, 4);
      near("spd_a", 100 * FREQ_MUL, sa);
      near("acc_a", 0, aa);
      near("spd_b", 100 * FREQ_MUL, sb);
      near("acc_b", 0, ab);
      chk("period_mode", 2'h0, 32'(pm));
      chk("fault_spd", 0, 32'(fs));
      run(200, 0, 2'h3, 4);
      chk("fault_spd", 1, 32'(fs));
      do_reset;
      run(4, 0, 2'h1, 200);
      repeat (30) @(posedge ref_clk);
      chk("spd_a", DIVIDEND / 200, sa);
      chk("period_mode", 2'h3, 32'(pm));
      repeat (4800) @(posedge ref_clk);
      chk("spd_a", 0, sa);
      // Filter at 8 samples of 1 ms: halfway through the first speed step
      fsel <= 4'h1;
      do_reset;
      run(150, 150, 2'h3, 4);
      near("spd_a", 100 * FREQ_MUL / 2, sa);
      near("spd_b", 100 * FREQ_MUL / 2, sb);
      fsel <= 4'h0;
      for (int k = 0; k < 2; k++) begin
         do_reset;
         stuck <= 2'(k + 1);
         lvl <= 1'(k);
         repeat (2450) @(posedge ref_clk);
         chk("fault_line", 0, 32'(fl));
         repeat (100) @(posedge ref_clk);
         chk("fault_line", k + 1, 32'(fl));
      end
      do_reset;
      skip <= 2'h1;
      @(posedge ref_clk);
      skip <= 2'h0;
      repeat (6) @(posedge ref_clk);
      chk("fault_line", 1, 32'(fl));
      chk("pos_a", 0, pa);
      rst <= 1;
      repeat (2) @(posedge ref_clk);
      chk("period_mode", 2'h3, 32'(pm));
      chk("safe_stop_req", 0, 32'(ssr));
      end_of_test;
   end
endmodule // ecm_crosscheck_bench
`default_nettype wire
